/* File: adf_regs.sv */
// Purpose: feature control and status register bank of a multichannel audio processor
// Assumes: APB slave, one 16-bit register per aligned 32-bit word, zero-wait answer
// Notes:   lock inputs come from other clock domains and are synchronised here
//
// Local design decision: register access over APB.
`include "adf_regs_defines.svh"
`default_nettype none
module adf_regs #(
    parameter logic [15:0] VENDOR_FIRST   = 16'hA5C3, // value arbitrary
    parameter logic [7:0]  VENDOR_SECOND  = 8'h5A,    // value arbitrary
    parameter logic [7:0]  REVISION       = 8'h01     // value arbitrary
) (
    // clock, reset, enable
    input  wire logic                     sys_clk_in,
    input  wire logic                     reset_in,
    input  wire logic                     ce_in,
    // register bus
    input  wire adf_regs_pkg::adf_apb_req_t apb_req_in,
    output var  adf_regs_pkg::adf_apb_rsp_t apb_rsp_out,
    // lock indications from the audio front end
    input  wire logic                     resampler_locked_in,
    input  wire logic                     spdif_locked_in,
    // feature controls
    output var  adf_regs_pkg::adf_feat_t    feat_out,
    output var  adf_regs_pkg::adf_coef_t    coef_out
);
    import adf_regs_pkg::*;

    adf_state_t state_ff;
    adf_state_t nxt_state;

    logic [9:0]  word_idx;
    logic        aligned;
    logic        setup;
    logic        write_fire;
    logic [15:0] rd_word;
    logic        mapped;

    assign word_idx   = apb_req_in.paddr[11:2];
    assign aligned    = (apb_req_in.paddr[1:0] == 2'h0);
    assign setup      = apb_req_in.psel && !apb_req_in.penable;
    assign write_fire = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite
                        && state_ff.rsp.pready && !state_ff.rsp.pslverr;

    // read mux, unused bits zero
    always_comb
    begin
        rd_word = 16'h0000;
        mapped  = aligned;
        case (word_idx)
            `ADF_IDX_PHANTOM:
            begin
                rd_word[0] = state_ff.phantom;
            end
            `ADF_IDX_EQ_SIDE:
            begin
                rd_word[1:0] = state_ff.eq_mode;
            end
            `ADF_IDX_BASS:
            begin
                rd_word[0] = state_ff.bass;
            end
            `ADF_IDX_BYPASS:
            begin
                rd_word[0] = state_ff.bypass;
            end
            `ADF_IDX_STATUS:
            begin
                rd_word[`ADF_ST_SRC_BIT]    = state_ff.src_s2;
                rd_word[`ADF_ST_SPDIF_BIT]  = state_ff.spdif_s2;
                rd_word[`ADF_ST_CFMUTE_BIT] = state_ff.cf_mute;
                rd_word[`ADF_ST_CHMUTE_BIT] = state_ff.ch_mute;
            end
            `ADF_IDX_COEF_LO:
            begin
                rd_word = state_ff.coef_lo;
            end
            `ADF_IDX_COEF_HI:
            begin
                rd_word[`ADF_CH_IDX_MSB:`ADF_CH_IDX_LSB] = state_ff.coef_idx;
                rd_word[`ADF_CH_RW_BIT]                  = state_ff.coef_rw;
                rd_word[`ADF_CH_VAL_MSB:0]               = state_ff.coef_hi;
            end
            `ADF_IDX_VID_FIRST:
            begin
                rd_word = VENDOR_FIRST;
            end
            `ADF_IDX_VID_SECOND:
            begin
                rd_word = {VENDOR_SECOND, REVISION};
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        nxt_state = state_ff;
        // answer is prepared in the setup cycle and shown for the access cycle
        nxt_state.rsp.pready  = setup;
        nxt_state.rsp.pslverr = setup && !mapped;
        if (setup && !apb_req_in.pwrite && mapped)
        begin
            nxt_state.rsp.prdata = {16'h0000, rd_word};
        end
        else if (setup)
        begin
            nxt_state.rsp.prdata = 32'h0000_0000;
        end
        // two-stage synchronisers, flag high while unlocked
        nxt_state.src_s1   = !resampler_locked_in;
        nxt_state.src_s2   = state_ff.src_s1;
        nxt_state.spdif_s1 = !spdif_locked_in;
        nxt_state.spdif_s2 = state_ff.spdif_s1;
        nxt_state.coef_strobe = 1'b0;
        if (write_fire)
        begin
            case (word_idx)
                `ADF_IDX_PHANTOM:
                begin
                    nxt_state.phantom = apb_req_in.pwdata[0];
                end
                `ADF_IDX_EQ_SIDE:
                begin
                    nxt_state.eq_mode = apb_req_in.pwdata[1:0];
                end
                `ADF_IDX_BASS:
                begin
                    nxt_state.bass = apb_req_in.pwdata[0];
                end
                `ADF_IDX_BYPASS:
                begin
                    nxt_state.bypass = apb_req_in.pwdata[0];
                end
                `ADF_IDX_STATUS:
                begin
                    // lock flags are not stored
                    nxt_state.cf_mute = apb_req_in.pwdata[`ADF_ST_CFMUTE_BIT];
                    nxt_state.ch_mute = apb_req_in.pwdata[`ADF_ST_CHMUTE_BIT];
                end
                `ADF_IDX_COEF_LO:
                begin
                    nxt_state.coef_lo = apb_req_in.pwdata[15:0];
                end
                `ADF_IDX_COEF_HI:
                begin
                    // writing the high word launches the coefficient transfer
                    nxt_state.coef_idx    = apb_req_in.pwdata[`ADF_CH_IDX_MSB:`ADF_CH_IDX_LSB];
                    nxt_state.coef_rw     = apb_req_in.pwdata[`ADF_CH_RW_BIT];
                    nxt_state.coef_hi     = apb_req_in.pwdata[`ADF_CH_VAL_MSB:0];
                    nxt_state.coef_strobe = 1'b1;
                end
                default:
                begin
                    // identification words ignore writes
                    nxt_state.coef_strobe = 1'b0;
                end
            endcase
        end
        // effective feature enables, bypass overrides all processing but the automute enables
        nxt_state.feat.bypass       = nxt_state.bypass;
        nxt_state.feat.phantom_en   = nxt_state.phantom && !nxt_state.bypass;
        nxt_state.feat.eq_en        = (|nxt_state.eq_mode) && !nxt_state.bypass;
        nxt_state.feat.side_fire_en = nxt_state.eq_mode[1] && !nxt_state.bypass;
        nxt_state.feat.bass_en      = nxt_state.bass && !nxt_state.bypass;
        nxt_state.feat.cf_mute_en   = nxt_state.cf_mute;
        nxt_state.feat.ch_mute_en   = nxt_state.ch_mute;
    end

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_ff                   <= '0;
            state_ff.phantom           <= `ADF_RST_PHANTOM;
            state_ff.eq_mode           <= `ADF_RST_EQ_MODE;
            state_ff.bass              <= `ADF_RST_BASS;
            state_ff.bypass            <= `ADF_RST_BYPASS;
            state_ff.src_s1            <= `ADF_RST_UNLOCK;
            state_ff.src_s2            <= `ADF_RST_UNLOCK;
            state_ff.spdif_s1          <= `ADF_RST_UNLOCK;
            state_ff.spdif_s2          <= `ADF_RST_UNLOCK;
            state_ff.cf_mute           <= `ADF_RST_CFMUTE;
            state_ff.ch_mute           <= `ADF_RST_CHMUTE;
            state_ff.feat.cf_mute_en   <= `ADF_RST_CFMUTE;
            state_ff.feat.ch_mute_en   <= `ADF_RST_CHMUTE;
        end
        else if (ce_in)
        begin
            state_ff <= nxt_state;
        end
    end

    assign apb_rsp_out = state_ff.rsp;
    assign feat_out    = state_ff.feat;
    assign coef_out    = {state_ff.coef_strobe, state_ff.coef_idx, state_ff.coef_rw,
                          state_ff.coef_hi, state_ff.coef_lo};

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    phantom_write_a: assert property (
        (ce_in && write_fire && word_idx == `ADF_IDX_PHANTOM)
        |=> (state_ff.phantom == $past(apb_req_in.pwdata[0]))
    ) else $error("phantom bit not stored");

    side_fire_map_a: assert property (
        feat_out.side_fire_en |-> (feat_out.eq_en && state_ff.eq_mode[1])
    ) else $error("side firing without equaliser");

    eq_off_a: assert property (
        (state_ff.eq_mode == 2'h0) |-> !feat_out.eq_en
    ) else $error("equaliser on with mode zero");

    bypass_override_a: assert property (
        feat_out.bypass |-> !(feat_out.phantom_en || feat_out.eq_en
                              || feat_out.side_fire_en || feat_out.bass_en)
    ) else $error("processing active during bypass");

    bass_write_a: assert property (
        (ce_in && write_fire && word_idx == `ADF_IDX_BASS && !state_ff.bypass
         && apb_req_in.pwdata[0])
        |=> feat_out.bass_en [*1] ##0 state_ff.bass
    ) else $error("bass management not enabled by write");

    status_read_a: assert property (
        (ce_in && setup && !apb_req_in.pwrite && aligned && word_idx == `ADF_IDX_STATUS)
        |=> (apb_rsp_out.prdata[1:0] == {$past(state_ff.spdif_s2), $past(state_ff.src_s2)})
    ) else $error("lock flags not read back");

    lock_sync_a: assert property (
        (ce_in && spdif_locked_in) ##1 (ce_in && spdif_locked_in) |=> !state_ff.spdif_s2
    ) else $error("spdif lock not seen after two stages");

    mute_write_a: assert property (
        (ce_in && write_fire && word_idx == `ADF_IDX_STATUS)
        |=> ({feat_out.ch_mute_en, feat_out.cf_mute_en}
             == $past(apb_req_in.pwdata[11:10]))
    ) else $error("automute enables not stored");

    coef_launch_a: assert property (
        (ce_in && write_fire && word_idx == `ADF_IDX_COEF_HI)
        |=> (coef_out.strobe && coef_out.index == $past(apb_req_in.pwdata[15:8]))
    ) else $error("coefficient launch missing");

    ident_read_a: assert property (
        (ce_in && setup && !apb_req_in.pwrite && aligned
         && word_idx == `ADF_IDX_VID_SECOND)
        |=> (apb_rsp_out.prdata == {16'h0000, VENDOR_SECOND, REVISION})
    ) else $error("identification word wrong");

    unused_zero_a: assert property (
        (ce_in && setup && !apb_req_in.pwrite && aligned && word_idx == `ADF_IDX_PHANTOM)
        |=> (apb_rsp_out.prdata[31:1] == 31'h0000_0000)
    ) else $error("unused bits not zero");

    ready_pulse_a: assert property (
        (ce_in && apb_rsp_out.pready) |=> !apb_rsp_out.pready
    ) else $error("ready held over two cycles");

    phantom_gate_a: assert property (
        feat_out.phantom_en |-> (state_ff.phantom && !state_ff.bypass)
    ) else $error("phantom enable without control bit");

    eq_write_a: assert property (
        (ce_in && write_fire && word_idx == `ADF_IDX_EQ_SIDE)
        |=> (state_ff.eq_mode == $past(apb_req_in.pwdata[1:0]))
    ) else $error("equaliser mode not stored");

    side_fire_on_a: assert property (
        (state_ff.eq_mode[1] && !state_ff.bypass) |-> feat_out.side_fire_en
    ) else $error("side firing not enabled by upper mode bit");

    bypass_write_a: assert property (
        (ce_in && write_fire && word_idx == `ADF_IDX_BYPASS)
        |=> (feat_out.bypass == $past(apb_req_in.pwdata[0]))
    ) else $error("bypass bit not stored");

    src_sync_a: assert property (
        (ce_in && resampler_locked_in) ##1 (ce_in && resampler_locked_in)
        |=> !state_ff.src_s2
    ) else $error("resampler lock not seen after two stages");

    mute_read_a: assert property (
        (ce_in && setup && !apb_req_in.pwrite && aligned && word_idx == `ADF_IDX_STATUS)
        |=> (apb_rsp_out.prdata[11:10] == $past({state_ff.ch_mute, state_ff.cf_mute}))
    ) else $error("automute enables not read back");

    coef_low_a: assert property (
        (ce_in && write_fire && word_idx == `ADF_IDX_COEF_LO)
        |=> (coef_out.value[15:0] == $past(apb_req_in.pwdata[15:0]))
    ) else $error("coefficient low word not stored");

    strobe_pulse_a: assert property (
        (ce_in && coef_out.strobe) |=> !coef_out.strobe
    ) else $error("coefficient strobe longer than one cycle");

    ident_first_a: assert property (
        (ce_in && setup && !apb_req_in.pwrite && aligned
         && word_idx == `ADF_IDX_VID_FIRST)
        |=> (apb_rsp_out.prdata == {16'h0000, VENDOR_FIRST})
    ) else $error("first identification word wrong");

    ident_write_a: assert property (
        (ce_in && write_fire
         && (word_idx == `ADF_IDX_VID_FIRST || word_idx == `ADF_IDX_VID_SECOND))
        |=> ($stable(feat_out) && !coef_out.strobe)
    ) else $error("write to identification word had an effect");

    refuse_error_a: assert property (
        (ce_in && setup && !mapped)
        |=> (apb_rsp_out.pready && apb_rsp_out.pslverr && apb_rsp_out.prdata == 32'h0)
    ) else $error("unmapped access not refused");

    ce_freeze_a: assert property (
        !ce_in |=> $stable(state_ff)
    ) else $error("state moved while enable low");

endmodule
`default_nettype wire

/* File: adf_regs_defines.svh */
// Purpose: offsets, field positions, reset values of the audio feature register bank
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   definitions only
`ifndef ADF_REGS_DEFINES_SVH
`define ADF_REGS_DEFINES_SVH

// word indices of the registers
`define ADF_IDX_PHANTOM      10'h060
`define ADF_IDX_EQ_SIDE      10'h070
`define ADF_IDX_BASS         10'h072
`define ADF_IDX_BYPASS       10'h074
`define ADF_IDX_STATUS       10'h076
`define ADF_IDX_COEF_LO      10'h078
`define ADF_IDX_COEF_HI      10'h07A
`define ADF_IDX_VID_FIRST    10'h07C
`define ADF_IDX_VID_SECOND   10'h07E

// status register fields
`define ADF_ST_SRC_BIT       0
`define ADF_ST_SPDIF_BIT     1
`define ADF_ST_CFMUTE_BIT    10
`define ADF_ST_CHMUTE_BIT    11

// coefficient high word fields
`define ADF_CH_IDX_MSB       15
`define ADF_CH_IDX_LSB       8
`define ADF_CH_RW_BIT        7
`define ADF_CH_VAL_MSB       3

// reset values
`define ADF_RST_PHANTOM      1'h0
`define ADF_RST_EQ_MODE      2'h0
`define ADF_RST_BASS         1'h0
`define ADF_RST_BYPASS       1'h0
`define ADF_RST_UNLOCK       1'h1
`define ADF_RST_CFMUTE       1'h1
`define ADF_RST_CHMUTE       1'h0

`endif

/* File: adf_regs_pkg.sv */
// Purpose: types of the audio feature register bank
// Assumes: APB with 32-bit data, 12-bit byte address
// Notes:   all state of the bank is one packed struct
`default_nettype none
package adf_regs_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } adf_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } adf_apb_rsp_t;

    typedef struct packed {
        logic phantom_en;
        logic eq_en;
        logic side_fire_en;
        logic bass_en;
        logic bypass;
        logic cf_mute_en;
        logic ch_mute_en;
    } adf_feat_t;

    typedef struct packed {
        logic        strobe;
        logic [7:0]  index;
        logic        rw;
        logic [19:0] value;
    } adf_coef_t;

    typedef struct packed {
        adf_apb_rsp_t rsp;
        logic         phantom;
        logic [1:0]   eq_mode;
        logic         bass;
        logic         bypass;
        logic         src_s1;
        logic         src_s2;
        logic         spdif_s1;
        logic         spdif_s2;
        logic         cf_mute;
        logic         ch_mute;
        logic [15:0]  coef_lo;
        logic [7:0]   coef_idx;
        logic         coef_rw;
        logic [3:0]   coef_hi;
        logic         coef_strobe;
        adf_feat_t    feat;
    } adf_state_t;

endpackage
`default_nettype wire

/* File: tb_audio_dsp_feature_registers.sv */
// Purpose: self-checking bench of the audio feature register bank over APB
// Assumes: zero-wait APB slave, outputs settle one cycle after the access edge
// Notes:   driver notes expected answers in a queue, a monitor compares them
`default_nettype none
module tb_audio_dsp_feature_registers;
    timeunit 1ns;
    timeprecision 1ns;
    import adf_regs_pkg::*;

    localparam logic [15:0] VID_FIRST  = 16'h3C96; // value arbitrary
    localparam logic [7:0]  VID_SECOND = 8'h69;    // value arbitrary
    localparam logic [7:0]  REV_NUM    = 8'h07;    // value arbitrary

    typedef struct packed {
        logic        err;
        logic        chk;
        logic [31:0] data;
    } adf_note_t;

    logic         sys_clk_in;
    logic         reset_in;
    logic         res_lock;
    logic         spd_lock;
    adf_apb_req_t req;
    adf_apb_rsp_t rsp;
    adf_feat_t    feat;
    adf_coef_t    coef;
    adf_note_t    notes[$];
    adf_note_t    note;
    int           n_fail;
    int           compares;
    logic [31:0]  lo;
    logic [31:0]  hi;

    adf_regs #(.VENDOR_FIRST(VID_FIRST), .VENDOR_SECOND(VID_SECOND), .REVISION(REV_NUM))
    adf_regs_inst (
        .sys_clk_in          (sys_clk_in),
        .reset_in            (reset_in),
        .ce_in               (1'b1),
        .apb_req_in          (req),
        .apb_rsp_out         (rsp),
        .resampler_locked_in (res_lock),
        .spdif_locked_in     (spd_lock),
        .feat_out            (feat),
        .coef_out            (coef)
    );

    always #50 sys_clk_in = ~sys_clk_in;

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one transfer; returns just after the edge that took the answer
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       input logic err, input logic chk, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        notes.push_back('{err: err, chk: chk, data: exp});
        @(posedge sys_clk_in);
        req.penable <= 1'b1;
        do
        begin
            @(posedge sys_clk_in);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50)
            check(32'h0, 32'h1, "no answer");
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
        apb(1'b1, addr, wdata, 1'b0, 1'b0, 32'h0);
    endtask

    task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0, 1'b0, 1'b1, exp);
    endtask

    task automatic relock(input logic r, input logic s);
        @(posedge sys_clk_in);
        res_lock <= r;
        spd_lock <= s;
        repeat (3) @(posedge sys_clk_in);
    endtask

    // monitor: every answered access consumes the oldest note
    always @(posedge sys_clk_in)
    begin
        if (req.psel && req.penable && rsp.pready === 1'b1)
        begin
            note = notes.pop_front();
            check(32'(rsp.pslverr), 32'(note.err), "error flag");
            if (note.chk)
                check(rsp.prdata, note.data, "read data");
        end
    end

    initial
    begin
        repeat (4000) @(posedge sys_clk_in);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end

    initial
    begin
        void'($urandom(65821));
        sys_clk_in = 1'b0;
        reset_in   = 1'b1;
        res_lock   = 1'b0;
        spd_lock   = 1'b0;
        req        = '0;
        n_fail     = 0;
        compares   = 0;
        repeat (6) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        check(32'(feat), 32'h02, "features after reset");
        rd(12'h180, 32'h0);
        rd(12'h1C0, 32'h0);
        rd(12'h1C8, 32'h0);
        rd(12'h1D0, 32'h0);
        rd(12'h1D8, 32'h0403);
        rd(12'h1F0, 32'(VID_FIRST));
        rd(12'h1F8, 32'({VID_SECOND, REV_NUM}));
        wr(12'h180, 32'hFFFF_FFFF);
        check(32'(feat.phantom_en), 32'h1, "phantom enable");
        rd(12'h180, 32'h1);
        for (int m = 0; m < 4; m++)
        begin
            wr(12'h1C0, 32'(m));
            check(32'({feat.eq_en, feat.side_fire_en}), (m == 0) ? 0 : (m == 1) ? 2 : 3,
                  "eq mode");
            rd(12'h1C0, 32'(m));
        end
        wr(12'h1C8, 32'hFFFF_FFFF);
        check(32'(feat), 32'h7A, "bass enable");
        rd(12'h1C8, 32'h1);
        wr(12'h1D0, 32'h1);
        check(32'(feat), 32'h06, "bypass overrides");
        rd(12'h1D0, 32'h1);
        wr(12'h1D0, 32'h0);
        check(32'(feat), 32'h7A, "bypass released");
        wr(12'h1D8, 32'hFFFF_FFFF);
        check(32'({feat.cf_mute_en, feat.ch_mute_en}), 32'h3, "mute enables set");
        rd(12'h1D8, 32'h0C03);
        relock(1'b1, 1'b0);
        rd(12'h1D8, 32'h0C02);
        relock(1'b1, 1'b1);
        rd(12'h1D8, 32'h0C00);
        relock(1'b0, 1'b1);
        rd(12'h1D8, 32'h0C01);
        wr(12'h1D8, 32'h0);
        check(32'({feat.cf_mute_en, feat.ch_mute_en}), 32'h0, "mute enables clear");
        rd(12'h1D8, 32'h0001);
        for (int k = 0; k < 3; k++)
        begin
            lo = $urandom;
            hi = $urandom;
            wr(12'h1E0, lo);
            wr(12'h1E8, hi);
            check(32'(coef), 32'({1'b1, hi[15:8], hi[7], hi[3:0], lo[15:0]}),
                  "coefficient strobe");
            @(posedge sys_clk_in);
            #1;
            check(32'(coef.strobe), 32'h0, "strobe single cycle");
            rd(12'h1E0, lo & 32'h0000_FFFF);
            rd(12'h1E8, hi & 32'h0000_FF8F);
        end
        wr(12'h1F0, $urandom);
        wr(12'h1F8, $urandom);
        rd(12'h1F0, 32'(VID_FIRST));
        rd(12'h1F8, 32'({VID_SECOND, REV_NUM}));
        apb(1'b0, 12'h100, 32'h0, 1'b1, 1'b1, 32'h0);
        apb(1'b1, 12'h182, 32'h0, 1'b1, 1'b1, 32'h0);
        rd(12'h180, 32'h1);
        @(posedge sys_clk_in);
        reset_in <= 1'b1;
        @(posedge sys_clk_in);
        reset_in <= 1'b0;
        #1;
        check(32'(feat), 32'h02, "features after second reset");
        rd(12'h1C0, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
